/* logic/tfpa_map.svh */
// Register offsets, field positions, reset values and counts for the timer add-on block.
// Functional notes
// - Force bit one acts at next count transition.
// - Forced compare sets no flag, no interrupt.
// - First-channel mask bits 7:3 enable port pins.
// - Compare copies masked data bits onto port.
// - Event mode counts each selected input edge.
// - Gated mode counts clock/64 while not inhibited.
// - Input sampled even when pin is output.
// - Enable bit on/off; mode bit event/gated.
// - Edge bit picks edge or inhibit level.
// - Overflow flag sets on wrap to zero.
// - Overflow flag requests interrupt when enabled.
// - Edge flag sets on each selected edge; here only while the enable bit is set.
// - Edge flag requests interrupt when enabled.
// - Flags clear only by writing one.
// - Count updates apart from software reads; here on the same rising edge as the read capture.
// - Count keeps value through reset, always accessible.
// - Periodic clock is clock/2^13 then /1..8.
// - Each period sets flag; enable requests interrupt.
// - First flag only after one full period.
// - Divider free-running; period from previous timeout.
// - Rate codes give 2^13..2^16 cycle periods.
`ifndef TFPA_MAP_SVH
`define TFPA_MAP_SVH
`define TFPA_OFF_FORCE   8'h00
`define TFPA_OFF_MASK    8'h04
`define TFPA_OFF_DATA    8'h08
`define TFPA_OFF_DDR     8'h0c
`define TFPA_OFF_CTL     8'h10
`define TFPA_OFF_FLAGS   8'h14
`define TFPA_OFF_IRQEN   8'h18
`define TFPA_OFF_COUNT   8'h1c
`define TFPA_OFF_PORTA   8'h20
`define TFPA_CTL_EN      6
`define TFPA_CTL_MODE    5
`define TFPA_CTL_EDGE    4
`define TFPA_FLG_RTI     6
`define TFPA_FLG_OVF     5
`define TFPA_FLG_EDGE    4
`define TFPA_FLG_MASK    8'h70
`define TFPA_OC1_MASK    8'hf8
`define TFPA_RST_BYTE    8'h00
`define TFPA_GATE_DIV    64
`define TFPA_RTI_EXP     13
`define TFPA_RESP_OKAY   2'h0
`define TFPA_RESP_SLVERR 2'h2
`endif

/* logic/tfpa_pkg.sv */
// Types shared by the timer add-on block.
package tfpa_pkg;
  typedef struct packed {
    logic       enable;
    logic       mode;
    logic       edge_sel;
    logic [1:0] rate;
  } tfpa_ctl_type;

  typedef enum logic [3:0] {
    TFPA_SEL_FORCE = 4'h0,
    TFPA_SEL_MASK  = 4'h1,
    TFPA_SEL_DATA  = 4'h2,
    TFPA_SEL_DDR   = 4'h3,
    TFPA_SEL_CTL   = 4'h4,
    TFPA_SEL_FLAGS = 4'h5,
    TFPA_SEL_IRQEN = 4'h6,
    TFPA_SEL_COUNT = 4'h7,
    TFPA_SEL_PORTA = 4'h8,
    TFPA_SEL_NONE  = 4'hf
  } tfpa_sel_type;

  typedef enum logic [0:0] {
    TFPA_WR_IDLE = 1'b0,
    TFPA_WR_RESP = 1'b1
  } tfpa_wr_state_type;
endpackage

/* logic/tfpa_top.sv */
// Forced compares, first-channel port drive, pulse accumulator and periodic interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "tfpa_map.svh"
module tfpa_top
  import tfpa_pkg::*;
#(
  parameter int P_GATE_DIV = `TFPA_GATE_DIV,
  parameter int P_RTI_EXP  = `TFPA_RTI_EXP
) (
  input  wire logic        CLK_I,        // Bus clock, 100 MHz.
  input  wire logic        RST_I,        // Asynchronous reset, active high.
  input  wire logic        CE_I,         // Clock enable, freezes state when low.
  input  wire logic [7:0]  S_AWADDR_I,   // Write address.
  input  wire logic        S_AWVALID_I,  // Write address valid.
  output logic             S_AWREADY_O,  // Write address ready.
  input  wire logic [31:0] S_WDATA_I,    // Write data.
  input  wire logic [3:0]  S_WSTRB_I,    // Write strobes.
  input  wire logic        S_WVALID_I,   // Write data valid.
  output logic             S_WREADY_O,   // Write data ready.
  output logic [1:0]       S_BRESP_O,    // Write response.
  output logic             S_BVALID_O,   // Write response valid.
  input  wire logic        S_BREADY_I,   // Write response ready.
  input  wire logic [7:0]  S_ARADDR_I,   // Read address.
  input  wire logic        S_ARVALID_I,  // Read address valid.
  output logic             S_ARREADY_O,  // Read address ready.
  output logic [31:0]      S_RDATA_O,    // Read data.
  output logic [1:0]       S_RRESP_O,    // Read response.
  output logic             S_RVALID_O,   // Read data valid.
  input  wire logic        S_RREADY_I,   // Read data ready.
  input  wire logic        TCNT_TICK_I,  // Timer count transition strobe.
  input  wire logic        OC1_MATCH_I,  // First channel counter match strobe.
  input  wire logic [7:0]  PA_I,         // Port A pin levels.
  output logic [7:0]       PA_O,         // Port A output levels.
  output logic [7:0]       PA_OE_O,      // Port A output enables.
  output logic [4:0]       FORCE_O,      // Forced compare strobes, bit 0 is channel one.
  output logic             OVF_IRQ_O,    // Accumulator overflow request.
  output logic             EDGE_IRQ_O,   // Accumulator edge request.
  output logic             RTI_IRQ_O     // Periodic interrupt request.
);

  localparam int GW = $clog2(P_GATE_DIV);
  localparam int RW = P_RTI_EXP + 3;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  function automatic tfpa_sel_type reg_sel(input logic [7:0] addr);
    unique case (addr)
      `TFPA_OFF_FORCE: reg_sel = TFPA_SEL_FORCE;
      `TFPA_OFF_MASK:  reg_sel = TFPA_SEL_MASK;
      `TFPA_OFF_DATA:  reg_sel = TFPA_SEL_DATA;
      `TFPA_OFF_DDR:   reg_sel = TFPA_SEL_DDR;
      `TFPA_OFF_CTL:   reg_sel = TFPA_SEL_CTL;
      `TFPA_OFF_FLAGS: reg_sel = TFPA_SEL_FLAGS;
      `TFPA_OFF_IRQEN: reg_sel = TFPA_SEL_IRQEN;
      `TFPA_OFF_COUNT: reg_sel = TFPA_SEL_COUNT;
      `TFPA_OFF_PORTA: reg_sel = TFPA_SEL_PORTA;
      default:         reg_sel = TFPA_SEL_NONE;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  logic              awready_r;
  logic              wready_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic [1:0]        bresp_r;
  tfpa_wr_state_type wr_state_r;
  logic              aw_held_r;
  logic              w_held_r;
  logic [7:0]        awaddr_r;
  logic [7:0]        wbyte_r;
  logic              wlane_r;
  logic [7:0]        mask_r;
  logic [7:0]        data_r;
  logic [7:0]        ddr_r;
  logic [7:0]        porta_r;
  tfpa_ctl_type      ctl_r;
  logic [7:0]        flags_r;
  logic [7:0]        irqen_r;
  logic [7:0]        count_r;
  logic [4:0]        pend_r;
  logic [4:0]        force_r;
  logic [2:0]        pai_sync_r;
  logic              pai_r;
  logic              pai_d_r;
  logic [GW-1:0]     gate_cnt_r;
  logic [RW-1:0]     rti_cnt_r;
  logic              ovf_irq_r;
  logic              edge_irq_r;
  logic              rti_irq_r;

  // --------------------------------------------------------------------
  // Combinational terms
  // --------------------------------------------------------------------
  tfpa_sel_type wsel;
  tfpa_sel_type rsel;
  logic         wr_fire;
  logic         wr_ok;
  logic [7:0]   rd_byte;
  logic [4:0]   new_force;
  logic         oc1_act;
  logic         sel_edge;
  logic         gate_tick;
  logic         count_inc;
  logic [RW-1:0] rti_mask;
  logic         rti_tick;
  logic [7:0]   flag_set;
  logic [7:0]   flag_clr;
  logic [7:0]   porta_nxt;
  logic [7:0]   drive_mask;

  assign wsel    = reg_sel(awaddr_r);
  assign rsel    = reg_sel(S_ARADDR_I);
  assign wr_fire = CE_I && aw_held_r && w_held_r && (wr_state_r == TFPA_WR_IDLE);
  assign wr_ok   = wr_fire && wlane_r && (wsel != TFPA_SEL_NONE);

  always_comb begin
    new_force = 5'h00;
    if (wr_ok && (wsel == TFPA_SEL_FORCE)) begin
      for (int i = 0; i < 5; i++) begin
        new_force[i] = wbyte_r[7-i];
      end
    end
  end

  // A force on the first channel acts on the same count transition edge as a real match.
  assign oc1_act    = OC1_MATCH_I || (TCNT_TICK_I && pend_r[0]);
  assign drive_mask = oc1_act ? (mask_r & `TFPA_OC1_MASK) : 8'h00;

  always_comb begin
    porta_nxt = porta_r;
    if (wr_ok && (wsel == TFPA_SEL_PORTA)) begin
      porta_nxt = wbyte_r;
    end
    porta_nxt = (porta_nxt & ~drive_mask) | (data_r & drive_mask);
  end

  // Edge seen on the filtered input, whatever direction the pin has.
  assign sel_edge  = ctl_r.edge_sel ? (pai_r && !pai_d_r) : (!pai_r && pai_d_r);
  assign gate_tick = (gate_cnt_r == GW'(P_GATE_DIV - 1));

  always_comb begin
    count_inc = 1'b0;
    if (ctl_r.enable) begin
      if (!ctl_r.mode) begin
        count_inc = sel_edge;
      end else begin
        count_inc = gate_tick && (pai_r != ctl_r.edge_sel);
      end
    end
  end

  assign rti_mask = {RW{1'b1}} >> (2'd3 - ctl_r.rate);
  assign rti_tick = &(rti_cnt_r | ~rti_mask);

  always_comb begin
    flag_set = 8'h00;
    flag_set[`TFPA_FLG_RTI]  = rti_tick;
    flag_set[`TFPA_FLG_OVF]  = count_inc && (count_r == 8'hff);
    flag_set[`TFPA_FLG_EDGE] = ctl_r.enable && sel_edge;
    flag_clr = 8'h00;
    if (wr_ok && (wsel == TFPA_SEL_FLAGS)) begin
      flag_clr = wbyte_r;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (rsel)
      TFPA_SEL_FORCE: rd_byte = 8'h00;
      TFPA_SEL_MASK:  rd_byte = mask_r;
      TFPA_SEL_DATA:  rd_byte = data_r;
      TFPA_SEL_DDR:   rd_byte = ddr_r;
      TFPA_SEL_CTL: begin
        rd_byte[`TFPA_CTL_EN]   = ctl_r.enable;
        rd_byte[`TFPA_CTL_MODE] = ctl_r.mode;
        rd_byte[`TFPA_CTL_EDGE] = ctl_r.edge_sel;
        rd_byte[1:0]            = ctl_r.rate;
      end
      TFPA_SEL_FLAGS: rd_byte = flags_r;
      TFPA_SEL_IRQEN: rd_byte = irqen_r;
      TFPA_SEL_COUNT: rd_byte = count_r;
      TFPA_SEL_PORTA: rd_byte = porta_r;
      TFPA_SEL_NONE:  rd_byte = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------
  // Bus write channel
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      awready_r  <= 1'b1;
      wready_r   <= 1'b1;
      aw_held_r  <= 1'b0;
      w_held_r   <= 1'b0;
      awaddr_r   <= 8'h00;
      wbyte_r    <= 8'h00;
      wlane_r    <= 1'b0;
      bresp_r    <= `TFPA_RESP_OKAY;
      wr_state_r <= TFPA_WR_IDLE;
    end else if (CE_I) begin
      if (S_AWVALID_I && awready_r) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= S_AWADDR_I;
        awready_r <= 1'b0;
      end
      if (S_WVALID_I && wready_r) begin
        w_held_r <= 1'b1;
        wbyte_r  <= S_WDATA_I[7:0];
        wlane_r  <= S_WSTRB_I[0];
        wready_r <= 1'b0;
      end
      unique case (wr_state_r)
        TFPA_WR_IDLE: begin
          if (wr_fire) begin
            bresp_r    <= (wsel == TFPA_SEL_NONE) ? `TFPA_RESP_SLVERR : `TFPA_RESP_OKAY;
            wr_state_r <= TFPA_WR_RESP;
          end
        end
        TFPA_WR_RESP: begin
          if (S_BREADY_I) begin
            aw_held_r  <= 1'b0;
            w_held_r   <= 1'b0;
            awready_r  <= 1'b1;
            wready_r   <= 1'b1;
            wr_state_r <= TFPA_WR_IDLE;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Bus read channel
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `TFPA_RESP_OKAY;
    end else if (CE_I) begin
      if (S_ARVALID_I && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= {24'h00_0000, rd_byte};
        rresp_r   <= (rsel == TFPA_SEL_NONE) ? `TFPA_RESP_SLVERR : `TFPA_RESP_OKAY;
      end else if (rvalid_r && S_RREADY_I) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mask_r  <= `TFPA_RST_BYTE;
      data_r  <= `TFPA_RST_BYTE;
      ddr_r   <= `TFPA_RST_BYTE;
      irqen_r <= `TFPA_RST_BYTE;
      ctl_r   <= '0;
    end else if (wr_ok) begin
      unique case (wsel)
        TFPA_SEL_MASK:  mask_r  <= wbyte_r & `TFPA_OC1_MASK;
        TFPA_SEL_DATA:  data_r  <= wbyte_r & `TFPA_OC1_MASK;
        TFPA_SEL_DDR:   ddr_r   <= wbyte_r;
        TFPA_SEL_IRQEN: irqen_r <= wbyte_r & `TFPA_FLG_MASK;
        TFPA_SEL_CTL: begin
          ctl_r.enable   <= wbyte_r[`TFPA_CTL_EN];
          ctl_r.mode     <= wbyte_r[`TFPA_CTL_MODE];
          ctl_r.edge_sel <= wbyte_r[`TFPA_CTL_EDGE];
          ctl_r.rate     <= wbyte_r[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Forced compares and port A drive
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pend_r  <= 5'h00;
      force_r <= 5'h00;
    end else if (CE_I) begin
      if (TCNT_TICK_I) begin
        force_r <= pend_r;
        pend_r  <= new_force;
      end else begin
        force_r <= 5'h00;
        pend_r  <= pend_r | new_force;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      porta_r <= `TFPA_RST_BYTE;
    end else if (CE_I) begin
      porta_r <= porta_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Accumulator input conditioning
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pai_sync_r <= 3'h0;
      pai_r      <= 1'b0;
      pai_d_r    <= 1'b0;
    end else if (CE_I) begin
      pai_sync_r <= {pai_sync_r[1:0], PA_I[7]};
      if (pai_sync_r[1] == pai_sync_r[2]) begin
        pai_r <= pai_sync_r[2];
      end
      pai_d_r <= pai_r;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gate_cnt_r <= '0;
    end else if (CE_I) begin
      gate_cnt_r <= gate_tick ? '0 : gate_cnt_r + GW'(1);
    end
  end

  // The count has no reset so that its value survives a reset; a software
  // write in the same cycle as an increment wins, and every update lands on
  // the same rising clock edge as the read capture, which sees the prior count.
  always_ff @(posedge CLK_I) begin
    if (CE_I) begin
      if (wr_ok && (wsel == TFPA_SEL_COUNT)) begin
        count_r <= wbyte_r;
      end else if (count_inc) begin
        count_r <= count_r + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------
  // Periodic divider
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rti_cnt_r <= '0;
    end else if (CE_I) begin
      rti_cnt_r <= rti_cnt_r + RW'(1);
    end
  end

  // --------------------------------------------------------------------
  // Flags and requests
  // --------------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flags_r <= `TFPA_RST_BYTE;
    end else if (CE_I) begin
      flags_r <= ((flags_r & ~flag_clr) | flag_set) & `TFPA_FLG_MASK;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ovf_irq_r  <= 1'b0;
      edge_irq_r <= 1'b0;
      rti_irq_r  <= 1'b0;
    end else if (CE_I) begin
      ovf_irq_r  <= flags_r[`TFPA_FLG_OVF] && irqen_r[`TFPA_FLG_OVF];
      edge_irq_r <= flags_r[`TFPA_FLG_EDGE] && irqen_r[`TFPA_FLG_EDGE];
      rti_irq_r  <= flags_r[`TFPA_FLG_RTI] && irqen_r[`TFPA_FLG_RTI];
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign S_AWREADY_O = awready_r;
  assign S_WREADY_O  = wready_r;
  assign S_BVALID_O  = (wr_state_r == TFPA_WR_RESP);
  assign S_BRESP_O   = bresp_r;
  assign S_ARREADY_O = arready_r;
  assign S_RVALID_O  = rvalid_r;
  assign S_RDATA_O   = rdata_r;
  assign S_RRESP_O   = rresp_r;
  assign PA_O        = porta_r;
  assign PA_OE_O     = ddr_r;
  assign FORCE_O     = force_r;
  assign OVF_IRQ_O   = ovf_irq_r;
  assign EDGE_IRQ_O  = edge_irq_r;
  assign RTI_IRQ_O   = rti_irq_r;

endmodule
`default_nettype wire

/* sim/tfpa_props.sv */
// Port checks for the timer add-on block.
`timescale 1ns/1ps
`default_nettype none
module tfpa_props #(
  parameter int P_RTI_EXP = 13
) (
  input wire logic        CLK_I,       // Bus clock.
  input wire logic        RST_I,       // Reset.
  input wire logic        S_BVALID_O,  // Write response valid.
  input wire logic        S_RVALID_O,  // Read data valid.
  input wire logic [31:0] S_RDATA_O,   // Read data.
  input wire logic        TCNT_TICK_I, // Count transition.
  input wire logic        OC1_MATCH_I, // First channel match.
  input wire logic [7:0]  PA_O,        // Port latch.
  input wire logic [7:0]  PA_OE_O,     // Port enables.
  input wire logic [4:0]  FORCE_O,     // Force strobes.
  input wire logic        OVF_IRQ_O,   // Overflow request.
  input wire logic        EDGE_IRQ_O,  // Edge request.
  input wire logic        RTI_IRQ_O    // Periodic request.
);
  logic [31:0] cyc_r;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cyc_r <= 32'h0;
    end else if (cyc_r < 32'h00ffffff) begin
      cyc_r <= cyc_r + 32'h1;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_force_on_tick: assert property (FORCE_O != 5'h00 |-> $past(TCNT_TICK_I))
    else $error("force strobe without count transition");
  a_port_cause: assert property ($changed(PA_O) |->
    $past(TCNT_TICK_I) || $past(OC1_MATCH_I) || $rose(S_BVALID_O))
    else $error("port latch changed without cause");
  a_ovf_clear: assert property ($fell(OVF_IRQ_O) |-> $past(S_BVALID_O))
    else $error("overflow request dropped without write");
  a_edge_clear: assert property (EDGE_IRQ_O && !S_BVALID_O |=> EDGE_IRQ_O)
    else $error("edge request dropped without write");
  a_rti_clear: assert property (RTI_IRQ_O ##1 !RTI_IRQ_O |-> $past(S_BVALID_O))
    else $error("periodic request dropped without write");
  a_rti_first: assert property ($rose(RTI_IRQ_O) |-> cyc_r > (1 << P_RTI_EXP))
    else $error("periodic request before one full period");
  a_rd_upper: assert property (S_RVALID_O |-> S_RDATA_O[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_oe_cause: assert property ($changed(PA_OE_O) |-> $rose(S_BVALID_O))
    else $error("port enables changed without write");
endmodule
`default_nettype wire

/* sim/tfpa_pin_src.sv */
// Model of the pulse source and port A pin wiring.
`timescale 1ns/1ps
`default_nettype none
module tfpa_pin_src (
  input  wire logic       clk_i,   // Bus clock.
  input  wire logic [7:0] pa_o_i,  // Port latch.
  input  wire logic [7:0] pa_oe_i, // Port enables.
  output logic      [7:0] pa_i_o   // Pin levels.
);
  logic src_r = 1'b1;
  // A driven pin shows its latch; an idle pin sits at the pull-up level, except pin 7, which shows the pulse source.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pa_i_o[i] = pa_oe_i[i] ? pa_o_i[i] : ((i == 7) ? src_r : 1'b1);
    end
  end
  // Half periods of eight cycles stay well below the clock/2 limit.
  task automatic pulses(input int n);
    repeat (2 * n) begin
      repeat (8) @(posedge clk_i);
      src_r <= ~src_r;
    end
    repeat (8) @(posedge clk_i);
  endtask
  task automatic level(input logic v);
    @(posedge clk_i);
    src_r <= v;
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* sim/tb_timer_force_pulse_accum_rti.sv */
// Self-checking bench for the timer add-on block.
`timescale 1ns/1ps
`default_nettype none
`include "tfpa_map.svh"
module tb_timer_force_pulse_accum_rti;
  logic        CLK_I = 1'b0, RST_I = 1'b1, CE_I = 1'b1;
  logic [7:0]  S_AWADDR_I = 8'h00, S_ARADDR_I = 8'h00;
  logic [31:0] S_WDATA_I = 32'h0, S_RDATA_O, v;
  logic        S_AWVALID_I = 1'b0, S_WVALID_I = 1'b0, S_BREADY_I = 1'b0;
  logic        S_ARVALID_I = 1'b0, S_RREADY_I = 1'b0;
  logic        TCNT_TICK_I = 1'b0, OC1_MATCH_I = 1'b0;
  logic        S_AWREADY_O, S_WREADY_O, S_BVALID_O, S_ARREADY_O, S_RVALID_O;
  logic        OVF_IRQ_O, EDGE_IRQ_O, RTI_IRQ_O;
  logic [1:0]  S_BRESP_O, S_RRESP_O;
  logic [7:0]  PA_O, PA_OE_O;
  wire  [7:0]  PA_I;
  logic [4:0]  FORCE_O;
  logic [3:0]  S_WSTRB_I = 4'hf;
  int          failures = 0, checks_done = 0, cyc = 0, t0, t1;
  always #5 CLK_I = ~CLK_I;
  always @(posedge CLK_I) cyc <= cyc + 1;
  tfpa_top #(.P_GATE_DIV(4), .P_RTI_EXP(4)) uut (
    .CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .S_AWADDR_I(S_AWADDR_I),
    .S_AWVALID_I(S_AWVALID_I), .S_AWREADY_O(S_AWREADY_O), .S_WDATA_I(S_WDATA_I),
    .S_WSTRB_I(S_WSTRB_I), .S_WVALID_I(S_WVALID_I), .S_WREADY_O(S_WREADY_O),
    .S_BRESP_O(S_BRESP_O), .S_BVALID_O(S_BVALID_O), .S_BREADY_I(S_BREADY_I),
    .S_ARADDR_I(S_ARADDR_I), .S_ARVALID_I(S_ARVALID_I), .S_ARREADY_O(S_ARREADY_O),
    .S_RDATA_O(S_RDATA_O), .S_RRESP_O(S_RRESP_O), .S_RVALID_O(S_RVALID_O),
    .S_RREADY_I(S_RREADY_I), .TCNT_TICK_I(TCNT_TICK_I), .OC1_MATCH_I(OC1_MATCH_I),
    .PA_I(PA_I), .PA_O(PA_O), .PA_OE_O(PA_OE_O), .FORCE_O(FORCE_O),
    .OVF_IRQ_O(OVF_IRQ_O), .EDGE_IRQ_O(EDGE_IRQ_O), .RTI_IRQ_O(RTI_IRQ_O));
  tfpa_pin_src u_src (.clk_i(CLK_I), .pa_o_i(PA_O), .pa_oe_i(PA_OE_O), .pa_i_o(PA_I));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    logic ta, tw, b;
    b = 1'b0;
    @(posedge CLK_I);
    S_AWADDR_I <= a;
    S_WDATA_I <= {24'h0, d};
    S_AWVALID_I <= 1'b1;
    S_WVALID_I <= 1'b1;
    S_BREADY_I <= 1'b1;
    for (int n = 0; n < 40 && !b; n++) begin
      @(negedge CLK_I);
      ta = S_AWVALID_I & S_AWREADY_O;
      tw = S_WVALID_I & S_WREADY_O;
      b = S_BVALID_O;
      if (b) chk("bresp", {30'h0, er}, {30'h0, S_BRESP_O});
      @(posedge CLK_I);
      if (ta) S_AWVALID_I <= 1'b0;
      if (tw) S_WVALID_I <= 1'b0;
      if (b) S_BREADY_I <= 1'b0;
    end
    if (b !== 1'b1) chk("bvalid", 32'h1, 32'h0);
    @(negedge CLK_I);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, input logic [1:0] er = 2'h0);
    logic ta, r;
    r = 1'b0;
    q = 32'h0;
    @(posedge CLK_I);
    S_ARADDR_I <= a;
    S_ARVALID_I <= 1'b1;
    S_RREADY_I <= 1'b1;
    for (int n = 0; n < 40 && !r; n++) begin
      @(negedge CLK_I);
      ta = S_ARVALID_I & S_ARREADY_O;
      r = S_RVALID_O;
      q = S_RDATA_O;
      if (r) chk("rresp", {30'h0, er}, {30'h0, S_RRESP_O});
      @(posedge CLK_I);
      if (ta) S_ARVALID_I <= 1'b0;
      if (r) S_RREADY_I <= 1'b0;
    end
    if (r !== 1'b1) chk("rvalid", 32'h1, 32'h0);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(nm, e, v);
  endtask
  task automatic strobe(input logic m);
    @(posedge CLK_I);
    if (m) OC1_MATCH_I <= 1'b1;
    else TCNT_TICK_I <= 1'b1;
    @(posedge CLK_I);
    OC1_MATCH_I <= 1'b0;
    TCNT_TICK_I <= 1'b0;
    @(negedge CLK_I);
  endtask
  task automatic t_regs();
    chk("oe reset", 32'h0, PA_OE_O);
    rdc("ddr reset", `TFPA_OFF_DDR, 32'h0);
    wr(`TFPA_OFF_DDR, 8'h5a);
    rdc("ddr", `TFPA_OFF_DDR, 32'h5a);
    chk("oe", 32'h5a, PA_OE_O);
    S_WSTRB_I <= 4'he;
    wr(`TFPA_OFF_DDR, 8'hff);
    @(posedge CLK_I);
    S_WSTRB_I <= 4'hf;
    rdc("strobe off", `TFPA_OFF_DDR, 32'h5a);
    wr(`TFPA_OFF_MASK, 8'hff);
    rdc("mask", `TFPA_OFF_MASK, 32'hf8);
    rdc("force read", `TFPA_OFF_FORCE, 32'h0);
    wr(8'h40, 8'h11, 2'h2);
    rd(8'h40, v, 2'h2);
    chk("unmapped", 32'h0, v);
    wr(`TFPA_OFF_DDR, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_oc1();
    wr(`TFPA_OFF_MASK, 8'ha8);
    wr(`TFPA_OFF_DATA, 8'hf8);
    wr(`TFPA_OFF_PORTA, 8'h00);
    strobe(1'b1);
    chk("match port", 32'ha8, PA_O);
    wr(`TFPA_OFF_DATA, 8'h00);
    wr(`TFPA_OFF_FORCE, 8'h80);
    chk("force early", 32'h0, FORCE_O);
    chk("port held", 32'ha8, PA_O);
    strobe(1'b0);
    chk("force one", 32'h01, FORCE_O);
    chk("force port", 32'h0, PA_O);
    @(negedge CLK_I);
    chk("force once", 32'h0, FORCE_O);
    wr(`TFPA_OFF_FORCE, 8'hf8);
    strobe(1'b0);
    chk("force all", 32'h1f, FORCE_O);
    wr(`TFPA_OFF_FORCE, 8'h00);
    strobe(1'b0);
    chk("force zero", 32'h0, FORCE_O);
    wr(`TFPA_OFF_FORCE, 8'h80);
    @(posedge CLK_I);
    CE_I <= 1'b0;
    strobe(1'b0);
    chk("force frozen", 32'h0, FORCE_O);
    @(posedge CLK_I);
    CE_I <= 1'b1;
    strobe(1'b0);
    chk("force resumed", 32'h01, FORCE_O);
    $display("test compare done");
  endtask
  task automatic t_event();
    wr(`TFPA_OFF_CTL, 8'h40);
    wr(`TFPA_OFF_COUNT, 8'hfd);
    wr(`TFPA_OFF_FLAGS, 8'h70);
    wr(`TFPA_OFF_IRQEN, 8'h30);
    u_src.pulses(4);
    rdc("count fall", `TFPA_OFF_COUNT, 32'h01);
    rd(`TFPA_OFF_FLAGS, v);
    chk("flags", 32'h30, v & 32'h30);
    chk("ovf irq", 32'h1, OVF_IRQ_O);
    chk("edge irq", 32'h1, EDGE_IRQ_O);
    wr(`TFPA_OFF_FLAGS, 8'h10);
    wr(`TFPA_OFF_FLAGS, 8'h00);
    chk("edge clear", 32'h0, EDGE_IRQ_O);
    chk("ovf kept", 32'h1, OVF_IRQ_O);
    wr(`TFPA_OFF_IRQEN, 8'h00);
    chk("ovf masked", 32'h0, OVF_IRQ_O);
    rd(`TFPA_OFF_FLAGS, v);
    chk("ovf polled", 32'h20, v & 32'h20);
    wr(`TFPA_OFF_CTL, 8'h50);
    wr(`TFPA_OFF_COUNT, 8'h00);
    u_src.pulses(3);
    rdc("count rise", `TFPA_OFF_COUNT, 32'h03);
    wr(`TFPA_OFF_CTL, 8'h10);
    u_src.pulses(2);
    rdc("count off", `TFPA_OFF_COUNT, 32'h03);
    wr(`TFPA_OFF_CTL, 8'h50);
    wr(`TFPA_OFF_PORTA, 8'h00);
    wr(`TFPA_OFF_DDR, 8'h80);
    wr(`TFPA_OFF_PORTA, 8'h80);
    repeat (8) @(posedge CLK_I);
    rdc("count output", `TFPA_OFF_COUNT, 32'h04);
    wr(`TFPA_OFF_DDR, 8'h00);
    @(posedge CLK_I);
    RST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    rdc("count kept", `TFPA_OFF_COUNT, 32'h04);
    $display("test event done");
  endtask
  task automatic t_gated();
    for (int e = 0; e < 2; e++) begin
      wr(`TFPA_OFF_CTL, e[0] ? 8'h70 : 8'h60);
      u_src.level(e[0]);
      wr(`TFPA_OFF_COUNT, 8'h00);
      repeat (40) @(posedge CLK_I);
      rdc("gate held", `TFPA_OFF_COUNT, 32'h0);
      u_src.level(~e[0]);
      wr(`TFPA_OFF_COUNT, 8'h00);
      repeat (40) @(posedge CLK_I);
      rd(`TFPA_OFF_COUNT, v);
      chk("gate count", 32'h1, {31'h0, v >= 32'h9 && v <= 32'hc});
    end
    $display("test gated done");
  endtask
  task automatic wait_rti(output int t);
    int n;
    n = 0;
    while (RTI_IRQ_O !== 1'b0 && n < 2000) begin
      wr(`TFPA_OFF_FLAGS, 8'h40);
      n++;
    end
    while (RTI_IRQ_O !== 1'b1 && n < 2000) begin
      @(negedge CLK_I);
      n++;
    end
    if (n >= 2000) chk("rti wait", 32'h1, 32'h0);
    t = cyc;
  endtask
  task automatic t_rti();
    wr(`TFPA_OFF_IRQEN, 8'h40);
    for (int r = 0; r < 4; r++) begin
      wr(`TFPA_OFF_CTL, r[7:0]);
      wait_rti(t0);
      wait_rti(t1);
      chk("rti period", 32'h1 << (4 + r), t1 - t0);
    end
    wr(`TFPA_OFF_IRQEN, 8'h00);
    repeat (130) @(posedge CLK_I);
    chk("rti masked", 32'h0, RTI_IRQ_O);
    rd(`TFPA_OFF_FLAGS, v);
    chk("rti flag", 32'h40, v & 32'h40);
    $display("test periodic done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge CLK_I);
    RST_I <= 1'b0;
    t_regs();
    t_oc1();
    t_event();
    t_gated();
    t_rti();
    summarize();
  end
  initial begin
    #400000;
    failures++;
    summarize();
  end
endmodule
bind tfpa_top tfpa_props #(.P_RTI_EXP(P_RTI_EXP)) u_props (
  .CLK_I(CLK_I), .RST_I(RST_I), .S_BVALID_O(S_BVALID_O), .S_RVALID_O(S_RVALID_O),
  .S_RDATA_O(S_RDATA_O), .TCNT_TICK_I(TCNT_TICK_I), .OC1_MATCH_I(OC1_MATCH_I),
  .PA_O(PA_O), .PA_OE_O(PA_OE_O), .FORCE_O(FORCE_O), .OVF_IRQ_O(OVF_IRQ_O),
  .EDGE_IRQ_O(EDGE_IRQ_O), .RTI_IRQ_O(RTI_IRQ_O));
`default_nettype wire
